// *** src/msp_cfg.svh ***
`ifndef MSP_CFG_SVH
`define MSP_CFG_SVH

// Clock rate in kHz (12 MHz system clock)
`define MSP_CLK_KHZ 12000
// Blink half period in ms
`define MSP_BLINK_MS 50
// Blink half period in cycles, derived from the rate
`define MSP_BLINK_CYC ((`MSP_BLINK_MS) * (`MSP_CLK_KHZ))
// Wake pin must stay low longer than this many cycles
`define MSP_WAKE_MIN_CYC 2
// Width of the wake low-time counter
`define MSP_WAKE_CW 3
// Number of general-purpose pins
`define MSP_GPIO_N 3
// Reset value of each pin output enable bit (low enable = driving, so one = off)
`define MSP_GPIO_OE_RST_BIT 1'h1
// Reset level of the three indicator lamps
`define MSP_LED_RST 1'h1
// Reset value of the chirp permission (strap open)
`define MSP_CHIRP_RST 1'h1
// Reset value of the external PHY reset output enable (high = released / tri-state)
`define MSP_PHYRST_OE_RST 1'h1

`endif

// *** src/msp_misc_pins.sv ***
// Operation
// - Ethernet LED low at 100, high at 10
// - Low reset sets everything to its reset level immediately
// - Configuration load starts by itself after reset
// - Wake needs more than two cycles low
// - General pins come up as inputs
// - PHY reset output tri-state until enabled
// - PHY held in reset until software release
// - Strap high allows high-speed chirp
// - Strap low forces full speed, no chirp
// - Activity LED shows speed when idle
// - Activity LED blinks during bulk-out
// - Speed LED steady by bus speed
`timescale 1ns/1ps
`default_nettype none
`include "msp_cfg.svh"
module msp_misc_pins #(
    parameter int unsigned BLINK_CYC = `MSP_BLINK_CYC,
    parameter int unsigned GPIO_N = `MSP_GPIO_N
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Status from the PHY and USB cores
    input wire logic eth_is_100,
    input wire logic usb_high_speed,
    input wire logic bulk_out_active,
    // Software controls
    input wire logic [GPIO_N-1:0] gpio_oe_sw,
    input wire logic [GPIO_N-1:0] gpio_out_sw,
    input wire logic phy_rst_enable_sw,
    input wire logic phy_rst_release_sw,
    // Loader handshake
    input wire logic cfg_load_done,
    output logic cfg_load_start,
    // Pins from outside
    input wire logic external_wake_in_low,
    input wire logic force_full_speed_strap,
    input wire logic [GPIO_N-1:0] gpio_in,
    // Pins driven out
    output logic eth_rate_indicator,
    output logic usb_rate_indicator,
    output logic usb_activity_indicator,
    output logic [GPIO_N-1:0] gpio_out,
    output logic [GPIO_N-1:0] gpio_oe_n,
    output logic ext_phy_reset_out,
    output logic ext_phy_reset_oe_n,
    // Derived status
    output logic wake_request,
    output logic chirp_allowed,
    output logic [GPIO_N-1:0] gpio_level
);
    // ==========================================
    // Elaboration checks
    // A blink count below two cannot toggle on the terminal count
    if (BLINK_CYC < 2) begin : g_bad_blink
        $error("BLINK_CYC must be at least 2");
    end
    if (GPIO_N < 1) begin : g_bad_gpio
        $error("GPIO_N must be at least 1");
    end
    // The wake counter saturates, so it must reach beyond the limit
    if (`MSP_WAKE_MIN_CYC >= (1 << `MSP_WAKE_CW) - 1) begin : g_bad_wake
        $error("wake counter too narrow for its limit");
    end

    // ==========================================
    // Pin synchronisers
    // Wake and strap share one stage module; general pins live in the state below
    msp_sync_if sif ();

    msp_pin_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .external_wake_in_low(external_wake_in_low),
        .force_full_speed_strap(force_full_speed_strap),
        .sync(sif.src)
    );

    // ==========================================
    // State
    // One register image; the comb block edits a copy of it
    typedef struct packed {
        msp_pkg::msp_load_e ld;                 // Loader start sequence
        logic [`MSP_WAKE_CW-1:0] wake_cnt;      // Cycles the wake pin stayed low
        logic [31:0] blink_cnt;                 // Blink half-period counter
        logic blink_ph;                         // Blink phase
        logic fs_locked; // Qualified strap, high forces full speed
        logic eth_led;
        logic usb_led;
        logic act_led;
        logic [GPIO_N-1:0] g_out;
        logic [GPIO_N-1:0] g_oe_n;
        logic [GPIO_N-1:0] gin1; // General pin stage one
        logic [GPIO_N-1:0] gin2; // Stage two, votes with stage three
        logic [GPIO_N-1:0] gin3; // Stage three
        logic [GPIO_N-1:0] g_lvl;
        logic prst_out;
        logic prst_oe_n;
        logic wake;
        logic chirp;
        logic start;
    } msp_top_s;

    msp_top_s s_q;
    msp_top_s s_d;

    // Next-state logic for every output and counter
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        // Loader kicks off once, right after reset release
        // The loader sees exactly one start pulse per reset
        case (s_q.ld)
            msp_pkg::MSP_LD_IDLE: begin
                s_d.ld = msp_pkg::MSP_LD_START;
            end
            msp_pkg::MSP_LD_START: begin
                s_d.start = 1'b1;
                s_d.ld = msp_pkg::MSP_LD_WAIT;
            end
            msp_pkg::MSP_LD_WAIT: begin
                if (cfg_load_done) begin
                    s_d.ld = msp_pkg::MSP_LD_DONE;
                end
            end
            msp_pkg::MSP_LD_DONE: begin
                s_d.ld = msp_pkg::MSP_LD_DONE;
            end
            default: begin
                s_d.ld = msp_pkg::MSP_LD_IDLE;
            end
        endcase
        // Strap is static on the board, so its qualified level is followed;
        // a latch at reset release would only see the synchroniser's pulled-up
        // reset value and lose a strap tied low
        s_d.fs_locked = sif.strap_fs;
        s_d.chirp = ~s_d.fs_locked;
        // Wake qualification: count low cycles, saturating
        // A bounce shorter than the limit clears the count and is lost
        if (sif.wake_low) begin
            if (s_q.wake_cnt != {`MSP_WAKE_CW{1'b1}}) begin
                s_d.wake_cnt = s_q.wake_cnt + `MSP_WAKE_CW'(1);
            end
        end else begin
            s_d.wake_cnt = '0;
        end
        s_d.wake = (s_d.wake_cnt > `MSP_WAKE_CW'(`MSP_WAKE_MIN_CYC));
        // Ethernet speed LED
        // Follows the PHY rate directly; this lamp never blinks
        s_d.eth_led = ~eth_is_100;
        // Speed LED: high at full speed, low at high speed, never blinks
        s_d.usb_led = ~(usb_high_speed & ~s_q.fs_locked);
        // Blink timer only runs during bulk-out
        // Each burst restarts the counter, so its first phase is a full half period
        if (bulk_out_active) begin
            if (s_q.blink_cnt >= BLINK_CYC - 1) begin
                s_d.blink_cnt = '0;
                s_d.blink_ph = ~s_q.blink_ph;
            end else begin
                s_d.blink_cnt = s_q.blink_cnt + 32'h1;
            end
            s_d.act_led = s_q.blink_ph;
        end else begin
            s_d.blink_cnt = '0;
            s_d.blink_ph = 1'b0;
            s_d.act_led = s_d.usb_led;
        end
        // Software steers the general pins; low enable drives
        s_d.g_oe_n = ~gpio_oe_sw;
        // Output value only reaches the pad where the enable is low
        s_d.g_out = gpio_out_sw;
        // Pin stages: the first feeds only the second; two and three vote
        s_d.gin1 = gpio_in;
        s_d.gin2 = s_q.gin1;
        s_d.gin3 = s_q.gin2;
        s_d.g_lvl = (s_q.gin2 == s_q.gin3) ? s_q.gin3 : s_q.g_lvl;
        // PHY reset: stays tri-state (pull holds PHY in reset) until enabled
        // The board's pull picks the reset level while the driver is off
        s_d.prst_oe_n = ~phy_rst_enable_sw;
        s_d.prst_out = phy_rst_release_sw;
    end

    // Reset forces every output to its safe level at once
    // Reset branch holds constants only, so release is clean
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Every field cleared first, then the few that idle high
            s_q <= '0;
            s_q.ld <= msp_pkg::MSP_LD_IDLE;
            // Lamps show full speed and 10 Mb/s until the cores report
            s_q.eth_led <= `MSP_LED_RST;
            s_q.usb_led <= `MSP_LED_RST;
            s_q.act_led <= `MSP_LED_RST;
            s_q.chirp <= `MSP_CHIRP_RST;
            // Pins released: general pins read only, PHY reset left to its pull
            s_q.g_oe_n <= {GPIO_N{`MSP_GPIO_OE_RST_BIT}};
            s_q.prst_oe_n <= `MSP_PHYRST_OE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs straight from flops
    // Every pin comes from s_q, so no combinational path reaches a pad
    assign eth_rate_indicator = s_q.eth_led;
    assign usb_rate_indicator = s_q.usb_led;
    assign usb_activity_indicator = s_q.act_led;
    assign gpio_out = s_q.g_out;
    assign gpio_oe_n = s_q.g_oe_n;
    assign gpio_level = s_q.g_lvl;
    assign ext_phy_reset_out = s_q.prst_out;
    assign ext_phy_reset_oe_n = s_q.prst_oe_n;
    assign wake_request = s_q.wake;
    assign chirp_allowed = s_q.chirp;
    assign cfg_load_start = s_q.start;
endmodule : msp_misc_pins
`default_nettype wire

// *** src/msp_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; a change counts once stages two and three agree
module msp_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Raw pins
    input wire logic external_wake_in_low,
    input wire logic force_full_speed_strap,
    // Qualified levels
    msp_sync_if.src sync
);
    // ==========================================
    // State
    typedef struct packed {
        logic [2:0] wk;    // Wake pin stages
        logic [2:0] fs;    // Strap stages
        logic wake_lvl;    // Accepted wake level
        logic fs_lvl;      // Accepted strap level
    } msp_sync_s;

    msp_sync_s s_q;
    msp_sync_s s_d;

    // Next state: shift, and accept only agreeing stages
    always_comb begin
        s_d = s_q;
        s_d.wk = {s_q.wk[1:0], external_wake_in_low};
        s_d.fs = {s_q.fs[1:0], force_full_speed_strap};
        if (s_q.wk[1] == s_q.wk[2]) begin
            s_d.wake_lvl = s_q.wk[2];
        end
        if (s_q.fs[1] == s_q.fs[2]) begin
            s_d.fs_lvl = s_q.fs[2];
        end
    end

    // Idle-high pins reset to the pulled-up level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{wk: 3'h7, fs: 3'h7, wake_lvl: 1'h1, fs_lvl: 1'h1};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync.wake_low = ~s_q.wake_lvl;
    assign sync.strap_fs = ~s_q.fs_lvl;
endmodule : msp_pin_sync
`default_nettype wire

// *** src/msp_pkg.sv ***
package msp_pkg;
    // Loader start sequence after reset
    typedef enum logic [1:0] {
        MSP_LD_IDLE,
        MSP_LD_START,
        MSP_LD_WAIT,
        MSP_LD_DONE
    } msp_load_e;
endpackage : msp_pkg

// *** src/msp_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Synchronised pin levels passed from the input stage to the top
interface msp_sync_if;
    logic wake_low;
    logic strap_fs;
    modport src (output wake_low, output strap_fs);
    modport dst (input wake_low, input strap_fs);
endinterface : msp_sync_if
`default_nettype wire

// *** verification/msp_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Board side: pins, strap, wake source, loader
module msp_far_model (
    // Clock
    input wire logic clk,
    // From the block
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe_n,
    input wire logic cfg_load_start,
    // To the block
    output logic [2:0] gpio_in,
    output logic cfg_load_done,
    output var logic external_wake_in_low = 1'b1,
    output var logic force_full_speed_strap = 1'b1
);
    logic [2:0] ld_q = 3'h0;
    // Pull-down wins wherever the block does not drive
    assign gpio_in = ~gpio_oe_n & gpio_out;
    // Pin zero feeds the external PHY power-down
    wire phy_pd = gpio_in[0];
    // Strap starts open, pulled high; set_strap ties it low or frees it
    // Loader answers a few cycles after its start
    always @(posedge clk) ld_q <= {ld_q[1:0], cfg_load_start};
    assign cfg_load_done = ld_q[2];
    // Hold the wake pin low for n cycles
    task pulse(input int n);
        @(posedge clk) external_wake_in_low <= 1'b0;
        repeat (n) @(posedge clk);
        external_wake_in_low <= 1'b1;
    endtask : pulse
    // Strap level on the board: 1 left open, 0 tied low
    task set_strap(input logic lvl);
        @(posedge clk) force_full_speed_strap <= lvl;
    endtask : set_strap
endmodule : msp_far_model
`default_nettype wire

// *** verification/msp_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module msp_props_chk #(
    parameter int unsigned GPIO_N = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Inputs watched
    input wire logic eth_is_100,
    input wire logic usb_high_speed,
    input wire logic bulk_out_active,
    input wire logic [GPIO_N-1:0] gpio_oe_sw,
    input wire logic phy_rst_enable_sw,
    input wire logic phy_rst_release_sw,
    input wire logic external_wake_in_low,
    input wire logic force_full_speed_strap,
    // Outputs watched
    input wire logic cfg_load_start,
    input wire logic eth_rate_indicator,
    input wire logic usb_rate_indicator,
    input wire logic usb_activity_indicator,
    input wire logic [GPIO_N-1:0] gpio_oe_n,
    input wire logic ext_phy_reset_out,
    input wire logic ext_phy_reset_oe_n,
    input wire logic wake_request,
    input wire logic chirp_allowed
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Length of current and last low run on the raw wake pin
    logic [2:0] run_q;
    logic [2:0] last_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 3'h0;
            last_q <= 3'h0;
        end else begin
            // Saturates so a long hold never wraps to a short one
            run_q <= external_wake_in_low ? 3'h0 : run_q + {2'h0, run_q != 3'h7};
            if (external_wake_in_low && run_q != 3'h0) begin
                last_q <= run_q;
            end
        end
    end
    eth_led_a: assert property (1 |=> eth_rate_indicator == !$past(eth_is_100))
        else $error("eth rate led wrong");
    speed_led_a: assert property (1 |=> usb_rate_indicator ==
        (!$past(usb_high_speed) || !$past(chirp_allowed))) else $error("usb rate led wrong");
    idle_led_a: assert property (!bulk_out_active |=>
        usb_activity_indicator == usb_rate_indicator) else $error("idle activity led wrong");
    led_blink_a: assert property (
        not ((bulk_out_active && $stable(usb_activity_indicator)) [*7]))
        else $error("activity led not blinking");
    strap_full_a: assert property (!force_full_speed_strap [*8] |=> !chirp_allowed)
        else $error("chirp allowed while forced full speed");
    strap_high_a: assert property (force_full_speed_strap [*8] |=> chirp_allowed)
        else $error("chirp blocked with strap open");
    gpio_dir_a: assert property (1 |=> gpio_oe_n == ~$past(gpio_oe_sw))
        else $error("gpio enable wrong");
    phy_tri_a: assert property (!phy_rst_enable_sw |=> ext_phy_reset_oe_n)
        else $error("phy reset driven while disabled");
    phy_level_a: assert property (1 |=> ext_phy_reset_out == $past(phy_rst_release_sw))
        else $error("phy reset level wrong");
    wake_min_a: assert property ($rose(wake_request) |-> run_q > 3'h2 || last_q > 3'h2)
        else $error("wake from short pulse");
    wake_bound_a: assert property (!external_wake_in_low [*8] |-> ##[0:4] wake_request)
        else $error("wake not raised");
    load_start_a: assert property ($rose(reset_n) |-> ##[0:4] cfg_load_start)
        else $error("load not started");
    cover property ($rose(wake_request));
    cover property ($rose(cfg_load_start));
    cover property (bulk_out_active && !usb_activity_indicator);
    cover property (!chirp_allowed);
endmodule : msp_props_chk
bind msp_misc_pins msp_props_chk #(.GPIO_N(GPIO_N)) u_chk (.clk, .reset_n, .eth_is_100,
    .usb_high_speed, .bulk_out_active, .gpio_oe_sw, .phy_rst_enable_sw, .phy_rst_release_sw,
    .external_wake_in_low, .cfg_load_start, .eth_rate_indicator, .usb_rate_indicator,
    .usb_activity_indicator, .gpio_oe_n, .ext_phy_reset_out, .ext_phy_reset_oe_n,
    .wake_request, .chirp_allowed, .force_full_speed_strap);
`default_nettype wire

// *** verification/test_misc_pins_status_indicators.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_misc_pins_status_indicators;
    // ==========
    // Wiring
    logic clk = 1'b0, reset_n = 1'b0, eth_is_100 = 1'b0, usb_high_speed = 1'b0;
    logic bulk_out_active = 1'b0, phy_rst_enable_sw = 1'b0, phy_rst_release_sw = 1'b0;
    logic [2:0] gpio_oe_sw = 3'h0, gpio_out_sw = 3'h0, gpio_in, gpio_out, gpio_oe_n, gpio_level;
    logic cfg_load_done, cfg_load_start, external_wake_in_low, force_full_speed_strap;
    logic eth_rate_indicator, usb_rate_indicator, usb_activity_indicator;
    logic ext_phy_reset_out, ext_phy_reset_oe_n, wake_request, chirp_allowed;
    int n_fail = 0, checks = 0, starts = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (cfg_load_start === 1'b1) starts++;
    // Short blink count keeps the run brief
    msp_misc_pins #(.BLINK_CYC(4)) dut (.clk, .reset_n, .eth_is_100, .usb_high_speed,
        .bulk_out_active, .gpio_oe_sw, .gpio_out_sw, .phy_rst_enable_sw, .phy_rst_release_sw,
        .cfg_load_done, .cfg_load_start, .external_wake_in_low, .force_full_speed_strap,
        .gpio_in, .eth_rate_indicator, .usb_rate_indicator, .usb_activity_indicator, .gpio_out,
        .gpio_oe_n, .ext_phy_reset_out, .ext_phy_reset_oe_n, .wake_request, .chirp_allowed,
        .gpio_level);
    msp_far_model far (.clk, .gpio_out, .gpio_oe_n, .cfg_load_start, .gpio_in, .cfg_load_done,
        .external_wake_in_low, .force_full_speed_strap);
    // ==========
    // Helpers
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task tally_and_finish;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // ==========
    // Scenarios
    task t_start;
        cyc(6);
        chk(starts, 1);
        chk(gpio_oe_n, 3'h7);
        chk(ext_phy_reset_oe_n, 1'b1);
        chk(chirp_allowed, 1'b1);
    endtask : t_start
    task t_speed;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) eth_is_100 <= i[0];
            usb_high_speed <= i[0];
            cyc(2);
            chk(eth_rate_indicator, !i[0]);
            chk(usb_rate_indicator, !i[0]);
            chk(usb_activity_indicator, !i[0]);
        end
    endtask : t_speed
    task t_blink;
        logic prev;
        int n;
        n = 0;
        @(posedge clk) bulk_out_active <= 1'b1;
        repeat (20) begin
            prev = usb_activity_indicator;
            cyc(1);
            if (usb_activity_indicator !== prev) n++;
        end
        chk(n >= 4 && n <= 6, 1'b1);
        @(posedge clk) bulk_out_active <= 1'b0;
        cyc(2);
        chk(usb_activity_indicator, !usb_high_speed);
    endtask : t_blink
    task t_strap;
        far.set_strap(1'b0);
        cyc(8);
        chk({chirp_allowed, usb_rate_indicator, usb_activity_indicator}, 3'h3);
        far.set_strap(1'b1);
        cyc(8);
        chk({chirp_allowed, usb_rate_indicator}, {1'b1, !usb_high_speed});
    endtask : t_strap
    task t_pins;
        @(posedge clk) gpio_oe_sw <= 3'h5;
        gpio_out_sw <= 3'h1;
        phy_rst_enable_sw <= 1'b1;
        cyc(8);
        chk({gpio_oe_n, gpio_out, gpio_level}, {3'h2, 3'h1, 3'h1});
        chk({ext_phy_reset_oe_n, ext_phy_reset_out}, 2'h0);
        @(posedge clk) phy_rst_release_sw <= 1'b1;
        cyc(2);
        chk({ext_phy_reset_oe_n, ext_phy_reset_out}, 2'h1);
    endtask : t_pins
    task t_wake;
        logic [15:0] seen;
        seen = 0;
        far.pulse(2);
        repeat (12) begin cyc(1); seen += wake_request; end
        chk(seen, 0);
        far.pulse(8);
        repeat (12) begin cyc(1); seen += wake_request; end
        chk(seen != 0, 1'b1);
        seen = 0;
        far.pulse(3);
        repeat (12) begin cyc(1); seen += wake_request; end
        chk(seen != 0, 1'b1);
    endtask : t_wake
    task t_reset;
        @(posedge clk) reset_n <= 1'b0;
        #2;
        chk({gpio_oe_n, ext_phy_reset_oe_n}, 4'hf);
        cyc(3);
        starts = 0;
        @(posedge clk) reset_n <= 1'b1;
        cyc(6);
        chk(starts, 1);
    endtask : t_reset
    // ==========
    // Main sequence and hang guard
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_start();
        t_speed();
        t_blink();
        t_strap();
        t_pins();
        t_wake();
        t_reset();
        tally_and_finish();
    end
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule : test_misc_pins_status_indicators
`default_nettype wire
